// ### rtl/rot_sub_pkg.sv
// package for the rotate / return / literal-subtract execution block
// assumes a 14-bit instruction word and an 8-bit data path
package rot_sub_pkg;
    localparam int OPW   = 14;
    localparam int DW    = 8;
    localparam int FAW   = 7;
    localparam int PCW   = 13;

    // opcode patterns
    localparam logic [5:0]  ROT_LEFT_TOP  = 6'h0d;
    localparam logic [5:0]  ROT_RIGHT_TOP = 6'h0c;
    localparam logic [4:0]  LIT_SUB_TOP   = 5'h1e;
    localparam logic [13:0] SUB_EXIT_CODE = 14'h0008;

    // field positions
    localparam int DEST_BIT = 7;
    localparam int MSB      = DW - 1;

    localparam logic [DW-1:0]  ZERO_BYTE = 8'h00;
    localparam logic [PCW-1:0] ZERO_PC   = 13'h0000;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_RLC   = 3'b001,
        OP_RRC   = 3'b010,
        OP_EXIT  = 3'b011,
        OP_LSUB  = 3'b100
    } op_type;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_FLUSH = 1'b1
    } state_type;

    typedef struct packed {
        logic carry;
        logic nibble_carry_flag;
        logic zero;
    } flags_type;

    typedef struct packed {
        op_type          op;
        logic            dest_file;
        logic [FAW-1:0]  file_addr;
        logic [DW-1:0]   literal;
    } decoded_type;
endpackage

// ### rtl/op_decoder.sv
// combinational opcode decoder for the four supported operations
// assumes the caller qualifies the word with its own valid signal
`timescale 1ns/1ps
module op_decoder
(
    // instruction
    input  wire logic [rot_sub_pkg::OPW-1:0] instr,
    // decoded fields
    output rot_sub_pkg::decoded_type         dec
);
    import rot_sub_pkg::*;

    always_comb
    begin
        dec.dest_file = instr[DEST_BIT];
        dec.file_addr = instr[FAW-1:0];
        dec.literal   = instr[DW-1:0];
        if (instr[13:8] == ROT_LEFT_TOP)
            dec.op = OP_RLC;
        else if (instr[13:8] == ROT_RIGHT_TOP)
            dec.op = OP_RRC;
        else if (instr[13:9] == LIT_SUB_TOP)
            dec.op = OP_LSUB;
        else if (instr == SUB_EXIT_CODE)
            dec.op = OP_EXIT;
        else
            dec.op = OP_NONE;
    end
endmodule

// ### rtl/rot_sub_exec.sv
// execution unit for rotate-through-carry, subroutine exit and
// literal-minus-accumulator; one instruction per cycle, none taken in the flush cycle after an exit
// assumes file read data is valid in the cycle the instruction is
// presented, and that stack_top_entry holds the return address
`timescale 1ns/1ps

// Contract
// - opcode 001101 d fffffff is the one-cycle left rotate through carry.
// - left rotate moves old carry into bit 0 and old bit 7 into carry only.
// - d=0 sends a rotate result to the accumulator, d=1 writes file f.
// - opcode 001100 d fffffff is the one-cycle right rotate through carry.
// - right rotate moves old carry into bit 7 and old bit 0 into carry only.
// - opcode 00000000001000 pops the stack into the program counter, no flags.
// - subroutine exit takes two cycles, the second flushing the fetched word.
// - opcode 11110x kkkkkkkk is the one-cycle literal-minus-accumulator.
// - literal minus accumulator goes to the accumulator, updating C, DC, Z.
// - carry is inverted borrow: set on zero or positive result.
module rot_sub_exec
(
    // clock and reset
    input  wire logic                         CLK,
    input  wire logic                         ARST_N,
    // instruction from fetch
    input  wire logic                         INSTR_VALID,
    input  wire logic [rot_sub_pkg::OPW-1:0]  INSTR,
    // file register read data and stack
    input  wire logic [rot_sub_pkg::DW-1:0]   FILE_RDATA,
    input  wire logic [rot_sub_pkg::PCW-1:0]  STACK_TOP_ENTRY,
    // file register write
    output logic                              FILE_WE,
    output logic [rot_sub_pkg::FAW-1:0]       FILE_ADDR,
    output logic [rot_sub_pkg::DW-1:0]        FILE_WDATA,
    // accumulator and status
    output logic [rot_sub_pkg::DW-1:0]        ACC,
    output rot_sub_pkg::flags_type            FLAGS,
    // program counter control
    output logic                              STACK_POP,
    output logic                              PC_LOAD,
    output logic [rot_sub_pkg::PCW-1:0]       PC_VALUE,
    output logic                              FLUSH,
    output logic                              BUSY
);
    import rot_sub_pkg::*;

    logic [1:0]      rst_sync;
    logic            rst_n;
    decoded_type     dec;
    state_type       state;
    state_type       next_state;
    logic            take;
    logic [DW-1:0]   rot_result;
    logic            rot_carry;
    logic [DW:0]     diff;
    logic [4:0]      low_diff;
    logic            exit_take;

    // rotate ops share the d field and the carry-only flag update
    function automatic logic is_rotate(input op_type op);
    begin
        is_rotate = (op == OP_RLC) || (op == OP_RRC);
    end
    endfunction

    // reset released through two flops
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    op_decoder u_dec
    (
        .instr (INSTR),
        .dec   (dec)
    );

    // words arriving in the flush cycle are the stale sequential fetch
    assign take = INSTR_VALID && (state == ST_RUN);

    // one decode of a taken return feeds pop, load and flush
    assign exit_take = take && (dec.op == OP_EXIT);

    always_comb
    begin
        rot_result = FILE_RDATA;
        rot_carry  = FLAGS.carry;
        case (dec.op)
            OP_RLC:
            begin
                rot_result = {FILE_RDATA[MSB-1:0], FLAGS.carry};
                rot_carry  = FILE_RDATA[MSB];
            end
            OP_RRC:
            begin
                rot_result = {FLAGS.carry, FILE_RDATA[MSB:1]};
                rot_carry  = FILE_RDATA[0];
            end
            default:
            begin
                rot_result = FILE_RDATA;
                rot_carry  = FLAGS.carry;
            end
        endcase
    end

    // ninth bit set means borrow out of the byte
    // low nibble is subtracted apart so the borrow out of bit 3 is
    // seen directly, without decoding it from the full difference
    assign diff = {1'b0, dec.literal} - {1'b0, ACC};
    assign low_diff = {1'b0, dec.literal[3:0]} - {1'b0, ACC[3:0]};

    always_comb
    begin
        case (state)
            ST_RUN:
                next_state = exit_take ? ST_FLUSH : ST_RUN;
            ST_FLUSH:
                next_state = ST_RUN;
            default:
                next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // accumulator
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            ACC <= ZERO_BYTE;
        else if (take)
        begin
            // file-destined rotates leave the accumulator alone
            if (is_rotate(dec.op) && !dec.dest_file)
                ACC <= rot_result;
            else if (dec.op == OP_LSUB)
                ACC <= diff[DW-1:0];
        end
    end

    // status flags
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            FLAGS <= '0;
        else if (take)
        begin
            // rotates touch carry only; nibble carry and zero hold
            if (is_rotate(dec.op))
                FLAGS.carry <= rot_carry;
            else if (dec.op == OP_LSUB)
            begin
                FLAGS.carry             <= ~diff[DW];
                FLAGS.nibble_carry_flag <= ~low_diff[4];
                FLAGS.zero <= (diff[DW-1:0] == ZERO_BYTE);
            end
        end
    end

    // file write-back
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            FILE_WE    <= 1'b0;
            FILE_ADDR  <= '0;
            FILE_WDATA <= ZERO_BYTE;
        end
        else
        begin
            // address and data run free; only the strobe qualifies them
            FILE_WE <= take && dec.dest_file &&
                       is_rotate(dec.op);
            FILE_ADDR  <= dec.file_addr;
            FILE_WDATA <= rot_result;
        end
    end

    // return: pop and load, no flags touched
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            STACK_POP <= 1'b0;
            PC_LOAD   <= 1'b0;
            PC_VALUE  <= ZERO_PC;
        end
        else
        begin
            STACK_POP <= exit_take;
            PC_LOAD   <= exit_take;
            // address held after the pulse so fetch may sample late
            if (exit_take)
                PC_VALUE <= STACK_TOP_ENTRY;
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            FLUSH <= 1'b0;
            BUSY  <= 1'b0;
        end
        else
        begin
            // busy mirrors flush: the only stall this unit makes
            FLUSH <= next_state == ST_FLUSH;
            BUSY  <= next_state == ST_FLUSH;
        end
    end
endmodule

// ### bench/rot_sub_exec_asserts.sv
// port checker for the rotate / return / literal-subtract unit
// assumes one clock domain; attached to rot_sub_exec by bind below
`timescale 1ns/1ps
module rot_sub_exec_asserts
    import rot_sub_pkg::*;
(
    // clock and reset
    input wire logic             CLK,
    input wire logic             ARST_N,
    // inputs of the unit
    input wire logic             INSTR_VALID,
    input wire logic [OPW-1:0]   INSTR,
    input wire logic [DW-1:0]    FILE_RDATA,
    input wire logic [PCW-1:0]   STACK_TOP_ENTRY,
    // outputs of the unit
    input wire logic             FILE_WE,
    input wire logic [FAW-1:0]   FILE_ADDR,
    input wire logic [DW-1:0]    FILE_WDATA,
    input wire logic [DW-1:0]    ACC,
    input wire flags_type        FLAGS,
    input wire logic             STACK_POP,
    input wire logic             PC_LOAD,
    input wire logic [PCW-1:0]   PC_VALUE,
    input wire logic             FLUSH,
    input wire logic             BUSY
);
    wire take = INSTR_VALID && !FLUSH;
    wire lft  = take && INSTR[13:8] == ROT_LEFT_TOP;
    wire rgt  = take && INSTR[13:8] == ROT_RIGHT_TOP;
    wire ext  = take && INSTR == SUB_EXIT_CODE;
    wire sub  = take && INSTR[13:9] == LIT_SUB_TOP;

    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    property p_rlc_file;
        $past(lft && INSTR[7]) |-> FILE_WE && ACC == $past(ACC)
            && FILE_ADDR == $past(INSTR[6:0])
            && FILE_WDATA == {$past(FILE_RDATA[6:0]), $past(FLAGS.carry)};
    endproperty
    a_rlc_file: assert property (p_rlc_file) else $error("rotl file");
    property p_rlc_acc;
        $past(lft && !INSTR[7]) |-> !FILE_WE && FLAGS.carry == $past(FILE_RDATA[7])
            && ACC == {$past(FILE_RDATA[6:0]), $past(FLAGS.carry)};
    endproperty
    a_rlc_acc: assert property (p_rlc_acc) else $error("rotl acc");
    property p_rrc;
        $past(rgt) |-> FILE_WE == $past(INSTR[7])
            && FLAGS.carry == $past(FILE_RDATA[0])
            && (FILE_WE ? FILE_WDATA : ACC)
               == {$past(FLAGS.carry), $past(FILE_RDATA[7:1])};
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotr result");
    property p_rot_only_c;
        $past(lft || rgt) |-> FLAGS[1:0] == $past(FLAGS[1:0]) && !STACK_POP;
    endproperty
    a_rot_only_c: assert property (p_rot_only_c) else $error("rot flags");
    property p_exit;
        $past(ext) |-> STACK_POP && PC_LOAD && FLAGS == $past(FLAGS)
            && PC_VALUE == $past(STACK_TOP_ENTRY);
    endproperty
    a_exit: assert property (p_exit) else $error("exit pop");
    property p_exit_flush;
        $past(ext) |-> FLUSH && BUSY
            ##1 !FLUSH && !STACK_POP && !FILE_WE && $stable(ACC);
    endproperty
    a_exit_flush: assert property (p_exit_flush) else $error("flush");
    property p_lsub;
        $past(sub) |-> !FILE_WE && ACC == $past(INSTR[7:0]) - $past(ACC);
    endproperty
    a_lsub: assert property (p_lsub) else $error("sub value");
    property p_lsub_c;
        $past(sub) |-> FLAGS.carry == ($past(INSTR[7:0]) >= $past(ACC));
    endproperty
    a_lsub_c: assert property (p_lsub_c) else $error("sub carry");
    property p_lsub_zdc;
        $past(sub) |-> FLAGS.zero == (ACC == 8'h00) && FLAGS.nibble_carry_flag
            == ($past(INSTR[3:0]) >= $past(ACC[3:0]));
    endproperty
    a_lsub_zdc: assert property (p_lsub_zdc) else $error("sub z dc");
endmodule

bind rot_sub_exec rot_sub_exec_asserts chk_u (.CLK, .ARST_N, .INSTR_VALID,
    .INSTR, .FILE_RDATA, .STACK_TOP_ENTRY, .FILE_WE, .FILE_ADDR, .FILE_WDATA,
    .ACC, .FLAGS, .STACK_POP, .PC_LOAD, .PC_VALUE, .FLUSH, .BUSY);

// ### bench/rot_sub_exec_tb_top.sv
// self-checking bench for rot_sub_exec: random op mix, queued results
// assumes the unit answers one cycle after each taken instruction
`timescale 1ns/1ps
module rot_sub_exec_tb_top;
    import rot_sub_pkg::*;
    logic CLK = 0, ARST_N = 0, INSTR_VALID = 0, issued = 0, pop = 0;
    logic FILE_WE, STACK_POP, PC_LOAD, FLUSH, BUSY, c = 0, dc = 0, z = 0;
    logic [OPW-1:0] INSTR = '0;
    logic [DW-1:0]  FILE_RDATA = '0, ACC, FILE_WDATA, acc = '0, r, k;
    logic [PCW-1:0] STACK_TOP_ENTRY = '0, PC_VALUE, pc = '0;
    logic [FAW-1:0] FILE_ADDR;
    flags_type      FLAGS;
    logic [43:0]    q[$];
    int err_count = 0, checks_done = 0, seed = 7087, n, sel;

    always #12.5 CLK = ~CLK;

    rot_sub_exec dut_u (.CLK, .ARST_N, .INSTR_VALID, .INSTR, .FILE_RDATA,
        .STACK_TOP_ENTRY, .FILE_WE, .FILE_ADDR, .FILE_WDATA, .ACC, .FLAGS,
        .STACK_POP, .PC_LOAD, .PC_VALUE, .FLUSH, .BUSY);

    task chk(input logic [43:0] g, input logic [43:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // file fields only matter while the write strobe is up
    always @(posedge CLK)
    begin
        if (issued)
        begin
            #1;
            chk({FILE_WE, FILE_WE ? FILE_ADDR : 7'h00,
                FILE_WE ? FILE_WDATA : 8'h00, ACC, FLAGS, STACK_POP,
                PC_LOAD, PC_VALUE, FLUSH, BUSY}, q.pop_front());
        end
    end

    initial
    begin
        repeat (5) @(negedge CLK);
        ARST_N = 1;
        repeat (3) @(negedge CLK);
        for (n = 0; n < 400; n++)
        begin
            k = $random(seed);
            r = $random(seed);
            if (n[3:2] == 2'b00)
                k = acc;
            FILE_RDATA = r;
            STACK_TOP_ENTRY = $random(seed);
            INSTR_VALID = 1;
            INSTR = {ROT_LEFT_TOP, k};
            sel = n < 6 ? n : {$random(seed)} % 6;
            case (sel)
                1: INSTR = {ROT_RIGHT_TOP, k};
                2: INSTR = SUB_EXIT_CODE;
                3: INSTR = {LIT_SUB_TOP, r[0], k};
                4: INSTR = 14'h0009;
                5: INSTR_VALID = 0;
            endcase
            if (sel == 0)
                {c, r} = {r, c};
            if (sel == 1)
                {r, c} = {c, r};
            if (sel < 2 && !k[7])
                acc = r;
            pop = sel == 2;
            if (pop)
                pc = STACK_TOP_ENTRY;
            if (sel == 3)
            begin
                dc = k[3:0] >= acc[3:0];
                c = k >= acc;
                acc = k - acc;
                z = acc == 8'h00;
            end
            issued = INSTR_VALID;
            if (issued)
                q.push_back({sel < 2 && k[7], sel < 2 && k[7] ? k[6:0] : 7'h00,
                    sel < 2 && k[7] ? r : 8'h00, acc, c, dc, z, pop, pop,
                    pc, pop, pop});
            @(negedge CLK);
            if (pop)
            begin
                // word offered in the flush cycle must be dropped
                issued = 0;
                INSTR = {LIT_SUB_TOP, k[0], r};
                @(negedge CLK);
            end
        end
        INSTR_VALID = 0;
        issued = 0;
        repeat (2) @(negedge CLK);
        if (q.size() != 0)
            err_count++;
        results();
    end

    initial
    begin
        #60000;
        err_count++;
        results();
    end
endmodule
